/* core/cov_pkg.sv */
// cov_pkg: constants and state types for the opcode variant decoder.
// assumes one 50 MHz clock and a synchronous active-high reset.
package cov_pkg;
  // wishbone register offsets (byte addresses)
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_MASK   = 8'h08;
  localparam logic [7:0] OFF_SR     = 8'h0C;
  // sticky event bits, same layout in status and mask
  localparam int EV_FP_TRAP  = 0;
  localparam int EV_BAD_CREG = 1;
  localparam int EV_XLAT_OP  = 2;
  localparam int EV_FRAME    = 3;
  localparam int EV_FETCH    = 4;
  localparam int EV_W        = 5;
  localparam int CTRL_EN     = 0;
  localparam logic       RST_CTRL_EN = 1'b1;
  localparam logic [4:0] RST_MASK    = 5'h00;
  localparam logic [15:0] RST_SR     = 16'h2700;
  // status register layout
  localparam int SR_T1 = 15;
  localparam int SR_T0 = 14;
  localparam int SR_S  = 13;
  localparam int SR_M  = 12;
  localparam int SR_I  = 8;
  localparam int SR_X  = 4;
  localparam logic [15:0] SR_IMPL = 16'hF71F;
  // opcode match masks and patterns
  localparam logic [15:0] OPM_XTEST  = 16'hFFD8;
  localparam logic [15:0] OPP_XTEST  = 16'hF548;
  localparam logic [15:0] OPM_XFLUSH = 16'hFFE0;
  localparam logic [15:0] OPP_XFLUSH = 16'hF500;
  localparam logic [15:0] OPM_CACHE  = 16'hFF00;
  localparam logic [15:0] OPP_CACHE  = 16'hF400;
  localparam logic [15:0] OPM_FP     = 16'hFE00;
  localparam logic [15:0] OPP_FP     = 16'hF200;
  localparam logic [15:0] OPM_CRMOVE = 16'hFFFE;
  localparam logic [15:0] OPP_CRMOVE = 16'h4E7A;
  localparam int CACHE_PUSH_BIT = 5;
  localparam int CACHE_SCOPE_LSB = 3;
  localparam logic [1:0] SCOPE_LINE = 2'h1;
  localparam logic [1:0] SCOPE_PAGE = 2'h2;
  localparam logic [1:0] SCOPE_ALL  = 2'h3;
  localparam logic [31:0] PAGE_MASK = 32'hFFFFF000;
  localparam logic [31:0] LINE_MASK = 32'hFFFFFFF0;
  // control register codes of the extension word
  localparam logic [11:0] CR_SRC_SPACE = 12'h000;
  localparam logic [11:0] CR_DST_SPACE = 12'h001;
  localparam logic [11:0] CR_CACHE     = 12'h002;
  localparam logic [11:0] CR_ITT0      = 12'h004;
  localparam logic [11:0] CR_ITT1      = 12'h005;
  localparam logic [11:0] CR_DTT0      = 12'h006;
  localparam logic [11:0] CR_DTT1      = 12'h007;
  localparam logic [11:0] CR_VBASE     = 12'h801;
  localparam logic [11:0] CR_XSTAT     = 12'h805;
  localparam logic [11:0] CR_UROOT     = 12'h806;
  localparam logic [11:0] CR_SROOT     = 12'h807;
  // stack frame formats
  localparam logic [3:0] FMT_NORMAL = 4'h0;
  localparam logic [3:0] FMT_THROW  = 4'h1;
  localparam logic [3:0] FMT_INSTR  = 4'h2;
  localparam logic [3:0] FMT_FPPOST = 4'h3;
  localparam logic [3:0] FMT_FPUNIMP = 4'h4;
  localparam logic [3:0] FMT_ACCERR = 4'h7;
  localparam logic [2:0] FC_CPU_SPACE = 3'h7;

  typedef struct packed {
    logic [2:0]  src_space;
    logic [2:0]  dst_space;
    logic [31:0] vbase;
    logic [31:0] cache_ctl;
    logic [31:0] dacc0;
    logic [31:0] dacc1;
    logic [31:0] iacc0;
    logic [31:0] iacc1;
    logic [31:0] acc_stat;
  } cov_creg_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] rdat;
    logic        irq;
    logic        en;
    logic [4:0]  stat;
    logic [4:0]  mask;
    logic [15:0] sr;
    logic        done;
    logic [31:0] result;
    logic        exc;
    logic        exc_fp;
    logic [3:0]  exc_fmt;
    logic        cache_op;
    logic        cache_push;
    logic [1:0]  cache_scope;
    logic [31:0] cache_addr;
    logic        frame_ok;
    logic        frame_err;
    logic        acc_fault;
    logic [2:0]  fc;
    logic        lock;
    logic        lock_end;
    logic [2:0]  beats_left;
  } cov_state_t;
endpackage : cov_pkg

/* core/cov_creg_if.sv */
// cov_creg_if: control register move port between decoder and register file.
// assumes both ends share clk_i; writes land at the next rising edge.
`timescale 1ns/1ps
interface cov_creg_if;
  logic        wr;
  logic [11:0] code;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        hit;
  modport dec  (output wr, code, wdata, input rdata, hit);
  modport regs (input wr, code, wdata, output rdata, hit);
endinterface : cov_creg_if

/* core/cov_creg_file.sv */
// cov_creg_file: control registers reachable by the control register move op.
// assumes the decoder only raises wr for codes that it checked itself.
`timescale 1ns/1ps
module cov_creg_file (
  input  wire logic clk_i,
  input  wire logic rst_i,
  cov_creg_if.regs  cr
);
  cov_pkg::cov_creg_t q;
  cov_pkg::cov_creg_t next_q;

  // write decode; old translation codes land on the access control registers
  always_comb begin
    next_q = q;
    if (cr.wr) begin
      case (cr.code)
        cov_pkg::CR_SRC_SPACE: next_q.src_space = cr.wdata[2:0];
        cov_pkg::CR_DST_SPACE: next_q.dst_space = cr.wdata[2:0];
        cov_pkg::CR_CACHE:     next_q.cache_ctl = cr.wdata;
        cov_pkg::CR_VBASE:     next_q.vbase     = cr.wdata;
        cov_pkg::CR_ITT0:      next_q.iacc0     = cr.wdata;
        cov_pkg::CR_ITT1:      next_q.iacc1     = cr.wdata;
        cov_pkg::CR_DTT0:      next_q.dacc0     = cr.wdata;
        cov_pkg::CR_DTT1:      next_q.dacc1     = cr.wdata;
        cov_pkg::CR_XSTAT:     next_q.acc_stat  = cr.wdata; // kept only, steers nothing
        default: ;
      endcase
    end
  end

  // read mux and the exact set of reachable registers
  always_comb begin
    cr.hit   = 1'b1;
    cr.rdata = 32'h00000000;
    case (cr.code)
      cov_pkg::CR_SRC_SPACE: cr.rdata = {29'h0, q.src_space};
      cov_pkg::CR_DST_SPACE: cr.rdata = {29'h0, q.dst_space};
      cov_pkg::CR_CACHE:     cr.rdata = q.cache_ctl;
      cov_pkg::CR_VBASE:     cr.rdata = q.vbase;
      cov_pkg::CR_ITT0:      cr.rdata = q.iacc0;
      cov_pkg::CR_ITT1:      cr.rdata = q.iacc1;
      cov_pkg::CR_DTT0:      cr.rdata = q.dacc0;
      cov_pkg::CR_DTT1:      cr.rdata = q.dacc1;
      cov_pkg::CR_XSTAT:     cr.rdata = q.acc_stat;
      default:               cr.hit   = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  a_xstat_store: assert property (@(posedge clk_i) disable iff (rst_i)
    cr.wr && cr.code == cov_pkg::CR_XSTAT |=> q.acc_stat == $past(cr.wdata))
    else $error("access unit status write lost");
  a_iacc_map: assert property (@(posedge clk_i) disable iff (rst_i)
    cr.wr && cr.code == cov_pkg::CR_ITT0 |=> q.iacc0 == $past(cr.wdata) && $stable(q.dacc0))
    else $error("instruction code did not reach instruction access register");
  a_dacc_map: assert property (@(posedge clk_i) disable iff (rst_i)
    cr.wr && cr.code == cov_pkg::CR_DTT1 |=> q.dacc1 == $past(cr.wdata) && $stable(q.iacc1))
    else $error("data code did not reach data access register");
  a_root_absent: assert property (@(posedge clk_i) disable iff (rst_i)
    cr.code == cov_pkg::CR_UROOT || cr.code == cov_pkg::CR_SROOT |-> !cr.hit)
    else $error("root pointer register must not exist");
endmodule : cov_creg_file

/* core/cov_decoder.sv */
// cov_decoder: opcode variant handling, exception formats, bus attributes.
// assumes a classic wishbone master, a synchronous active-high reset,
// and that opcode, access and frame requests are synchronous to clk_i.
//
// The address map and the Wishbone register port were decided locally.
`timescale 1ns/1ps
// What this block does
// - translation ops never raise an exception
// - page cache ops cover aligned 4 Kbyte
// - root pointer moves accepted without trap, registers absent
// - old translation status code reaches access status
// - translation register codes reach access controls
// - float ops trap with frame format 4
// - frame format 3 is never produced
// - frame format 3 is accepted on return
// - only instruction fetches must be aligned
// - space code 7 marks processor space
// - atomic sequences use lock and lock-end
// - status register trace, S, M, mask, flags
// - move reaches exactly the nine control registers
module cov_decoder (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             irq_o,
  input  wire logic        op_valid_i,
  input  wire logic [15:0] opcode_i,
  input  wire logic [15:0] ext_i,
  input  wire logic [31:0] reg_val_i,
  output logic             done_o,
  output logic      [31:0] result_o,
  output logic             exc_o,
  output logic             exc_fp_o,
  output logic      [3:0]  exc_fmt_o,
  output logic             cache_op_o,
  output logic             cache_push_o,
  output logic      [1:0]  cache_scope_o,
  output logic      [31:0] cache_addr_o,
  input  wire logic        frame_valid_i,
  input  wire logic [3:0]  frame_fmt_i,
  output logic             frame_ok_o,
  output logic             frame_err_o,
  input  wire logic        acc_valid_i,
  input  wire logic        acc_fetch_i,
  input  wire logic [31:0] acc_addr_i,
  input  wire logic        iack_i,
  output logic             acc_fault_o,
  output logic      [2:0]  address_space_code_o,
  input  wire logic        rmw_valid_i,
  input  wire logic [2:0]  rmw_beats_i,
  output logic             bus_lock_o,
  output logic             bus_lock_end_o,
  output logic      [15:0] sr_o
);
  cov_pkg::cov_state_t q;
  cov_pkg::cov_state_t next_q;
  cov_creg_if cr ();

  logic        is_xtest;
  logic        is_xflush;
  logic        is_cache;
  logic        is_fp;
  logic        is_crmove;
  logic        take;
  logic        is_root;
  logic        cr_bad;
  logic        bus_take;
  logic [31:0] wmask;
  logic [4:0]  ev;

  cov_creg_file u_creg (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .cr    (cr.regs)
  );

  // opcode classes, decoded straight off the request
  always_comb begin
    is_xtest  = (opcode_i & cov_pkg::OPM_XTEST) == cov_pkg::OPP_XTEST;
    is_xflush = (opcode_i & cov_pkg::OPM_XFLUSH) == cov_pkg::OPP_XFLUSH;
    is_cache  = (opcode_i & cov_pkg::OPM_CACHE) == cov_pkg::OPP_CACHE;
    is_fp     = (opcode_i & cov_pkg::OPM_FP) == cov_pkg::OPP_FP;
    is_crmove = (opcode_i & cov_pkg::OPM_CRMOVE) == cov_pkg::OPP_CRMOVE;
    take      = op_valid_i && q.en;
    is_root   = ext_i[11:0] == cov_pkg::CR_UROOT || ext_i[11:0] == cov_pkg::CR_SROOT;
    // a move in user state or to an unknown code is an illegal opcode
    cr_bad    = !q.sr[cov_pkg::SR_S] || (!cr.hit && !is_root);
  end

  // control register port; bit 0 of the opcode selects register-to-control
  assign cr.code  = ext_i[11:0];
  assign cr.wdata = reg_val_i;
  assign cr.wr    = take && is_crmove && opcode_i[0] && !cr_bad;

  // byte-lane write mask from the wishbone select lines
  always_comb begin
    wmask    = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    bus_take = wb_cyc_i && wb_stb_i && !q.ack;
  end

  // one process builds the whole next state
  always_comb begin
    next_q = q;
    ev     = 5'h00;
    next_q.ack = bus_take;
    next_q.done = 1'b0;
    next_q.exc = 1'b0;
    next_q.exc_fp = 1'b0;
    next_q.cache_op = 1'b0;
    next_q.frame_ok = 1'b0;
    next_q.frame_err = 1'b0;
    next_q.acc_fault = 1'b0;

    // opcode completion; translation ops fall through as no-ops
    if (take) begin
      next_q.done = 1'b1;
      if (is_xtest || is_xflush) begin
        ev[cov_pkg::EV_XLAT_OP] = 1'b1;
      end else if (is_fp) begin
        // every float op traps with the unimplemented-instruction frame
        next_q.exc     = 1'b1;
        next_q.exc_fp  = 1'b1;
        next_q.exc_fmt = cov_pkg::FMT_FPUNIMP;
        ev[cov_pkg::EV_FP_TRAP] = 1'b1;
      end else if (is_cache && opcode_i[4:3] != 2'h0) begin
        next_q.cache_op    = 1'b1;
        next_q.cache_push  = opcode_i[cov_pkg::CACHE_PUSH_BIT];
        next_q.cache_scope = opcode_i[4:3];
        case (opcode_i[4:3])
          cov_pkg::SCOPE_PAGE: next_q.cache_addr = reg_val_i & cov_pkg::PAGE_MASK;
          cov_pkg::SCOPE_LINE: next_q.cache_addr = reg_val_i & cov_pkg::LINE_MASK;
          default:             next_q.cache_addr = 32'h00000000;
        endcase
      end else if (is_crmove) begin
        if (cr_bad) begin
          next_q.exc     = 1'b1;
          next_q.exc_fmt = cov_pkg::FMT_NORMAL;
          ev[cov_pkg::EV_BAD_CREG] = 1'b1;
        end else begin
          // root pointer codes read as zero and trap nothing
          next_q.result = opcode_i[0] ? reg_val_i : (is_root ? 32'h00000000 : cr.rdata);
        end
      end
    end

    // returning frames: format 3 accepted though never produced
    if (frame_valid_i) begin
      case (frame_fmt_i)
        cov_pkg::FMT_NORMAL, cov_pkg::FMT_THROW, cov_pkg::FMT_INSTR,
        cov_pkg::FMT_FPPOST, cov_pkg::FMT_FPUNIMP, cov_pkg::FMT_ACCERR: next_q.frame_ok = 1'b1;
        default: begin
          next_q.frame_err = 1'b1;
          ev[cov_pkg::EV_FRAME] = 1'b1;
        end
      endcase
    end

    // only a fetch faults on an odd address; data may sit anywhere
    if (iack_i) begin
      next_q.fc = cov_pkg::FC_CPU_SPACE;
    end else if (acc_valid_i) begin
      next_q.fc = {q.sr[cov_pkg::SR_S], acc_fetch_i, !acc_fetch_i};
      if (acc_fetch_i && acc_addr_i[0]) begin
        next_q.acc_fault = 1'b1;
        ev[cov_pkg::EV_FETCH] = 1'b1;
      end
    end

    // locked sequence: lock on every beat, lock-end on the last
    if (q.lock) begin
      if (q.lock_end) begin
        next_q.lock     = 1'b0;
        next_q.lock_end = 1'b0;
      end else begin
        next_q.beats_left = q.beats_left - 3'h1;
        next_q.lock_end   = q.beats_left == 3'h1;
      end
    end else if (rmw_valid_i) begin
      next_q.lock       = 1'b1;
      next_q.beats_left = (rmw_beats_i == 3'h0) ? 3'h0 : rmw_beats_i - 3'h1;
      next_q.lock_end   = rmw_beats_i <= 3'h1;
    end

    // register writes; unmapped offsets ack and change nothing
    if (bus_take && wb_we_i) begin
      case (wb_adr_i)
        cov_pkg::OFF_CTRL: if (wb_sel_i[0]) next_q.en = wb_dat_i[cov_pkg::CTRL_EN];
        cov_pkg::OFF_MASK: if (wb_sel_i[0]) next_q.mask = wb_dat_i[4:0];
        cov_pkg::OFF_SR: next_q.sr = ((q.sr & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]))
                                     & cov_pkg::SR_IMPL;
        default: ;
      endcase
    end

    // register reads; a status read clears, but a new event wins
    next_q.rdat = 32'h00000000;
    if (bus_take && !wb_we_i) begin
      case (wb_adr_i)
        cov_pkg::OFF_CTRL:   next_q.rdat = {31'h0, q.en};
        cov_pkg::OFF_STATUS: next_q.rdat = {27'h0, q.stat};
        cov_pkg::OFF_MASK:   next_q.rdat = {27'h0, q.mask};
        cov_pkg::OFF_SR:     next_q.rdat = {16'h0, q.sr};
        default:             next_q.rdat = 32'h00000000;
      endcase
      if (wb_adr_i == cov_pkg::OFF_STATUS) begin
        next_q.stat = 5'h00;
      end
    end
    next_q.stat = next_q.stat | ev;
    next_q.irq  = |(next_q.stat & next_q.mask);
  end

  // state register; every output below is a flop of it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q      <= '0;
      q.en   <= cov_pkg::RST_CTRL_EN;
      q.mask <= cov_pkg::RST_MASK;
      q.sr   <= cov_pkg::RST_SR;
    end else begin
      q <= next_q;
    end
  end

  assign wb_ack_o             = q.ack;
  assign wb_dat_o             = q.rdat;
  assign irq_o                = q.irq;
  assign done_o               = q.done;
  assign result_o             = q.result;
  assign exc_o                = q.exc;
  assign exc_fp_o             = q.exc_fp;
  assign exc_fmt_o            = q.exc_fmt;
  assign cache_op_o           = q.cache_op;
  assign cache_push_o         = q.cache_push;
  assign cache_scope_o        = q.cache_scope;
  assign cache_addr_o         = q.cache_addr;
  assign frame_ok_o           = q.frame_ok;
  assign frame_err_o          = q.frame_err;
  assign acc_fault_o          = q.acc_fault;
  assign address_space_code_o = q.fc;
  assign bus_lock_o           = q.lock;
  assign bus_lock_end_o       = q.lock_end;
  assign sr_o                 = q.sr;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_lock_two;
    bus_lock_o && !bus_lock_end_o ##1 bus_lock_o && bus_lock_end_o ##1 !bus_lock_o;
  endsequence

  a_xlat_no_exc: assert property (take && (is_xtest || is_xflush) |=> done_o && !exc_o)
    else $error("translation op raised an exception");
  a_xlat_no_bus: assert property (take && (is_xtest || is_xflush) |-> !cr.wr ##1 !cache_op_o && $stable(result_o))
    else $error("translation op had a side effect");
  a_page_align: assert property (cache_op_o && cache_scope_o == cov_pkg::SCOPE_PAGE
    |-> cache_addr_o[11:0] == 12'h000)
    else $error("page cache op not 4 Kbyte aligned");
  a_root_quiet: assert property (take && is_crmove && is_root && sr_o[cov_pkg::SR_S]
    |=> !exc_o)
    else $error("root pointer move trapped");
  a_fp_frame: assert property (take && is_fp |=> exc_o && exc_fp_o && exc_fmt_o == 4'h4)
    else $error("float op did not trap with format 4");
  a_no_fmt3: assert property (exc_o |-> exc_fmt_o != 4'h3)
    else $error("format 3 frame produced");
  a_fmt3_accept: assert property (frame_valid_i && frame_fmt_i == 4'h3
    |=> frame_ok_o && !frame_err_o)
    else $error("format 3 frame refused");
  a_data_unaligned: assert property (acc_valid_i && !iack_i && !acc_fetch_i |=> !acc_fault_o)
    else $error("data access faulted on alignment");
  a_iack_space: assert property (iack_i |=> address_space_code_o == 3'h7)
    else $error("acknowledge not in processor space");
  a_lock_seq: assert property (rmw_valid_i && !bus_lock_o && rmw_beats_i == 3'h2 |=> s_lock_two)
    else $error("locked sequence malformed");
  a_sr_layout: assert property ((sr_o & ~cov_pkg::SR_IMPL) == 16'h0000)
    else $error("unimplemented status bit set");
  a_creg_set: assert property (take && is_crmove && ext_i[11:0] == 12'h003
    && sr_o[cov_pkg::SR_S] |=> exc_o)
    else $error("unlisted control register reached");
  // the level must agree with the registered status and mask it was built from
  a_irq_level: assert property (irq_o == |(q.stat & q.mask))
    else $error("interrupt level wrong");
endmodule : cov_decoder

/* verification/cpu_opcode_variant_handling_tb.sv */
// cpu_opcode_variant_handling_tb: self-checking bench for the opcode variant decoder.
// assumes cov_decoder is driven by this bench alone, one 50 MHz clock, sync active-high reset.
`timescale 1ns/1ps
module cpu_opcode_variant_handling_tb;
  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, op_valid_i, frame_valid_i;
  logic        acc_valid_i, acc_fetch_i, iack_i, rmw_valid_i;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i, frame_fmt_i, exc_fmt_o;
  logic [31:0] wb_dat_i, wb_dat_o, reg_val_i, result_o, cache_addr_o, acc_addr_i, q;
  logic [15:0] opcode_i, ext_i, sr_o;
  logic [2:0]  rmw_beats_i, address_space_code_o;
  logic [1:0]  cache_scope_o;
  logic        wb_ack_o, irq_o, done_o, exc_o, exc_fp_o, cache_op_o, cache_push_o;
  logic        frame_ok_o, frame_err_o, acc_fault_o, bus_lock_o, bus_lock_end_o;
  int          errors, tests_run, cycles;

  cov_decoder DUT (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .irq_o, .op_valid_i, .opcode_i, .ext_i, .reg_val_i, .done_o, .result_o,
    .exc_o, .exc_fp_o, .exc_fmt_o, .cache_op_o, .cache_push_o, .cache_scope_o, .cache_addr_o,
    .frame_valid_i, .frame_fmt_i, .frame_ok_o, .frame_err_o, .acc_valid_i, .acc_fetch_i, .acc_addr_i,
    .iack_i, .acc_fault_o, .address_space_code_o, .rmw_valid_i, .rmw_beats_i, .bus_lock_o,
    .bus_lock_end_o, .sr_o);

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // hang guard: the whole run needs well under a thousand cycles
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      errors++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    if (errors == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("unexpected %s expected %h seen %h", nm, exp, got);
      errors++;
    end
  endtask : chk

  // classic wishbone cycle; request held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1) @(posedge clk_i);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb

  // drops every request strobe armed by the caller, then samples mid-cycle
  task automatic go();
    @(posedge clk_i);
    op_valid_i    <= 1'b0;
    frame_valid_i <= 1'b0;
    acc_valid_i   <= 1'b0;
    iack_i        <= 1'b0;
    rmw_valid_i   <= 1'b0;
    @(negedge clk_i);
  endtask : go

  // only t_xlat issues translation ops on purpose; every other scenario keeps clear of them
  task automatic do_op(input logic [15:0] op, input logic [11:0] code, input logic [31:0] v);
    @(posedge clk_i);
    op_valid_i <= 1'b1;
    opcode_i   <= op;
    ext_i      <= {4'h0, code};
    reg_val_i  <= v;
    go();
  endtask : do_op

  task automatic t_regs();
    wb(1'b0, cov_pkg::OFF_SR, 32'h0);
    chk("sr reset", 32'h00002700, q);
    wb(1'b1, cov_pkg::OFF_SR, 32'hFFFFFFFF);
    wb(1'b0, cov_pkg::OFF_SR, 32'h0);
    chk("sr bits", 32'h0000F71F, q);
    wb(1'b1, cov_pkg::OFF_SR, 32'h00002700);
    wb(1'b1, 8'h10, 32'hFFFFFFFF);
    wb(1'b0, 8'h10, 32'h0);
    chk("unmapped", 32'h0, q);
    // decode disabled: opcode refused, no done
    wb(1'b1, cov_pkg::OFF_CTRL, 32'h0);
    do_op(16'hF200, 12'h000, 32'h0);
    chk("done off", 32'h0, done_o);
    wb(1'b1, cov_pkg::OFF_CTRL, 32'h1);
  endtask : t_regs

  task automatic t_xlat();
    wb(1'b1, cov_pkg::OFF_MASK, 32'h4);
    do_op(16'hF548, 12'h000, 32'h0);
    chk("test done", {31'h0, 1'b1}, {31'h0, done_o});
    chk("test exc", 32'h0, exc_o);
    do_op(16'hF500, 12'h000, 32'h0);
    chk("flush exc", {31'h0, 1'b1}, {31'h0, done_o & ~exc_o & ~cache_op_o});
    chk("flush sr", 32'h00002700, sr_o);
    @(negedge clk_i);
    chk("irq xlat", 32'h1, irq_o);
    wb(1'b0, cov_pkg::OFF_STATUS, 32'h0);
    chk("status xlat", 32'h4, q);
    @(negedge clk_i);
    @(negedge clk_i);
    chk("irq clear", 32'h0, irq_o);
  endtask : t_xlat

  task automatic t_cache();
    logic [31:0] ea;
    for (int s = 1; s < 4; s++) begin
      do_op(16'hF400 | (16'(s) << 3) | (s[0] ? 16'h0020 : 16'h0000), 12'h000, 32'hABCDEFFF);
      ea = (s == 2) ? 32'hABCDE000 : (s == 1) ? 32'hABCDEFF0 : 32'h0;
      chk("cache op", 32'h1, cache_op_o);
      chk("cache push", {31'h0, s[0]}, cache_push_o);
      chk("cache scope", 32'(s), cache_scope_o);
      chk("cache addr", ea, cache_addr_o);
    end
  endtask : t_cache

  task automatic t_fp();
    wb(1'b1, cov_pkg::OFF_MASK, 32'h1);
    for (int i = 0; i < 3; i++) begin
      do_op(16'hF200 + 16'(i * 16'h00FF), 12'h000, 32'h0);
      chk("fp exc", 32'h3, {exc_o, exc_fp_o});
      chk("fp fmt", 32'h4, exc_fmt_o);
    end
    @(negedge clk_i);
    chk("irq fp", 32'h1, irq_o);
    wb(1'b0, cov_pkg::OFF_STATUS, 32'h0);
    chk("status fp", 32'h1, q);
    wb(1'b1, cov_pkg::OFF_MASK, 32'h0);
    do_op(16'hF200, 12'h000, 32'h0);
    @(negedge clk_i);
    chk("irq masked", 32'h0, irq_o);
  endtask : t_fp

  task automatic t_creg();
    logic [11:0] cr[9] = '{cov_pkg::CR_SRC_SPACE, cov_pkg::CR_DST_SPACE, cov_pkg::CR_CACHE,
      cov_pkg::CR_ITT0, cov_pkg::CR_ITT1, cov_pkg::CR_DTT0, cov_pkg::CR_DTT1, cov_pkg::CR_VBASE,
      cov_pkg::CR_XSTAT};
    for (int i = 0; i < 9; i++) begin
      do_op(16'h4E7B, cr[i], 32'hC0DE0000 + 32'(i));
      chk("move wr exc", 32'h0, exc_o);
    end
    // read back after all writes so that aliased codes would show
    for (int i = 0; i < 9; i++) begin
      do_op(16'h4E7A, cr[i], 32'h0);
      chk("move rd", (i < 2) ? 32'(i) : 32'hC0DE0000 + 32'(i), result_o);
    end
    for (int i = 0; i < 2; i++) begin
      do_op(16'h4E7B, cov_pkg::CR_UROOT + 12'(i), 32'hFFFFFFFF);
      do_op(16'h4E7A, cov_pkg::CR_UROOT + 12'(i), 32'h0);
      chk("root ptr", 32'h0, result_o);
    end
    do_op(16'h4E7A, 12'h003, 32'h0);
    chk("bad code", 32'h10, {exc_o, exc_fmt_o});
    // user state: even a listed code traps as illegal
    wb(1'b1, cov_pkg::OFF_SR, 32'h00000700);
    do_op(16'h4E7A, cov_pkg::CR_VBASE, 32'h0);
    chk("user move", 32'h10, {exc_o, exc_fmt_o});
    wb(1'b1, cov_pkg::OFF_SR, 32'h00002700);
  endtask : t_creg

  // mid-run reset: registers and control registers return to their reset values
  task automatic t_reset();
    wb(1'b1, cov_pkg::OFF_MASK, 32'h1F);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, cov_pkg::OFF_MASK, 32'h0);
    chk("mask reset", 32'h0, q);
    chk("irq reset", 32'h0, irq_o);
    wb(1'b0, cov_pkg::OFF_STATUS, 32'h0);
    chk("status reset", 32'h0, q);
    wb(1'b0, cov_pkg::OFF_CTRL, 32'h0);
    chk("ctrl reset", 32'h1, q);
    do_op(16'h4E7A, cov_pkg::CR_VBASE, 32'h0);
    chk("vbase reset", 32'h0, result_o);
  endtask : t_reset

  task automatic t_frame();
    for (int f = 0; f < 16; f++) begin
      @(posedge clk_i);
      frame_valid_i <= 1'b1;
      frame_fmt_i   <= 4'(f);
      go();
      chk("frame ok", (f inside {0, 1, 2, 3, 4, 7}) ? 32'h2 : 32'h1, {frame_ok_o, frame_err_o});
    end
  endtask : t_frame

  task automatic t_acc(input logic f, input logic ia, input logic [31:0] a, input logic [3:0] ex);
    @(posedge clk_i);
    acc_valid_i <= 1'b1;
    acc_fetch_i <= f;
    iack_i      <= ia;
    acc_addr_i  <= a;
    go();
    chk("fault and space", 32'(ex), {acc_fault_o, address_space_code_o});
  endtask : t_acc

  task automatic t_lock(input logic [2:0] n);
    @(posedge clk_i);
    rmw_valid_i <= 1'b1;
    rmw_beats_i <= n;
    go();
    for (int k = 1; k <= n; k++) begin
      chk("lock beat", (k == n) ? 32'h3 : 32'h2, {bus_lock_o, bus_lock_end_o});
      @(negedge clk_i);
    end
    chk("lock idle", 32'h0, {bus_lock_o, bus_lock_end_o});
  endtask : t_lock

  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i, op_valid_i, frame_valid_i, acc_valid_i, acc_fetch_i} = '0;
    {iack_i, rmw_valid_i, wb_adr_i, wb_dat_i, opcode_i, ext_i, reg_val_i, frame_fmt_i} = '0;
    {acc_addr_i, rmw_beats_i, errors, tests_run, cycles} = '0;
    wb_sel_i = 4'hF;
    rst_i    = 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_xlat();
    t_cache();
    t_fp();
    t_creg();
    t_frame();
    t_acc(1'b0, 1'b0, 32'h00001003, 4'h5);
    t_acc(1'b1, 1'b0, 32'h00001001, 4'hE);
    t_acc(1'b1, 1'b0, 32'h00001002, 4'h6);
    t_acc(1'b0, 1'b1, 32'h00001000, 4'h7);
    t_lock(3'h2);
    t_lock(3'h1);
    t_reset();
    report_and_stop();
  end
endmodule : cpu_opcode_variant_handling_tb
